/* hdl/jtx_params.svh */
// Constants of the converter transmit link: symbols, taps, mode table
`ifndef JTX_PARAMS_SVH
`define JTX_PARAMS_SVH
`define JTX_LANES      4
`define JTX_SMP_NUM    16
`define JTX_SMP_N      9
`define JTX_SMP_NP     16
`define JTX_WORD_W     64
`define JTX_K28_5      8'hbc
`define JTX_K28_0      8'h1c
`define JTX_K28_3      8'h7c
`define JTX_ILAS_LAST  2'h3
`define JTX_SH_DATA    2'h1
`define JTX_T8_A       13
`define JTX_T8_B       14
`define JTX_T64_A      38
`define JTX_T64_B      57
// Mode table: {coding64, lanes, F, K}
`define JTX_MODE0      {1'b0, 3'h4, 5'h08, 9'h020}
`define JTX_MODE1      {1'b0, 3'h2, 5'h08, 9'h010}
`define JTX_MODE2      {1'b1, 3'h4, 5'h08, 9'h020}
`define JTX_MODE3      {1'b1, 3'h1, 5'h08, 9'h040}
`endif

/* hdl/jtx_pkg.sv */
// Types of the converter transmit link
package jtx_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_CGS, ST_ILAS, ST_DATA} jtx_state_e;
  typedef struct packed {
    logic       c64;
    logic [2:0] lanes;
    logic [4:0] f;
    logic [8:0] k;
  } jtx_mode_s;
  typedef logic [143:0] jtx_smp_t;
  typedef logic [121:0] jtx_scr_t;
endpackage

/* hdl/jtx_link.sv */
// Transmit transport and link layer of the converter serial interface
`timescale 1ns/1ps
`include "jtx_params.svh"
// Summary of operation
// R1 - Lanes use 8B/10B or 64B/66B by mode
// R2 - 8B/10B formats stay older-receiver compatible
// R3 - At most four lanes active
// R4 - SYNC low starts code group synchronization
// R5 - 64B/66B modes ignore SYNC for synchronization
// R6 - 64B/66B SYNC used only for NCO sync
// R7 - SYSREF resets multiframe/extended multiblock counter
// R8 - Samples packed into octets, frames, lanes
// R9 - N-bit samples sent as N'-bit fields
// R10 - Parameters from selected predefined transport mode
// R11 - Frames grouped into multiframes or multiblocks
// R12 - Scrambling optional in 8B/10B, forced 64B/66B
// R13 - Scrambling precedes line coding
// R14 - Alignment sequence never scrambled
// R15 - Distinct scrambling polynomial per coding
// R16 - Receiver self-synchronizes its descrambler
// R17 - FEC with 64B/66B; no 64B/80B; code only raises fec_active_o, adds no FEC bits to the lanes
// R18 - No CRC3, no command channel
// R19 - Subclass 1 only, subclass 0 compatible
// R20 - Lanes aligned within one link only
// R21 - SYNC timing suits older revisions
// R22 - Commas sent while SYNC asserted
// R23 - Alignment sequence starts next LMFC edge
// R24 - 64-bit block scrambled, 2-bit header added
// R25 - LMFC period F times K octets
// R26 - Reset clears counters, scrambler, idles lanes
module jtx_link (
  // Clock and reset
  input  wire logic                     ref_clk_i,
  input  wire logic                     rst_n_i,
  // Configuration
  input  wire logic [1:0]               transport_mode_select_i,
  input  wire logic                     scramble_enable_i,
  input  wire logic                     fec_enable_i,
  // Link control
  input  wire logic                     sync_request_pin_n_i,
  input  wire logic                     sysref_i,
  // Sample stream
  input  wire logic                     smp_valid_i,
  input  wire jtx_pkg::jtx_smp_t        smp_data_i,
  output logic                          smp_ready_o,
  // Lane outputs
  output logic [3:0][63:0]              lane_data_o,
  output logic [3:0][7:0]               lane_k_o,
  output logic [3:0][1:0]               lane_hdr_o,
  output logic [3:0]                    lane_valid_o,
  // Status
  output logic                          fec_active_o,
  output logic                          nco_sync_o,
  output logic                          lmfc_edge_o
);

  // ****************************************
  // Mode decode
  // ****************************************
  function automatic jtx_pkg::jtx_mode_s mode_cfg(input logic [1:0] sel);
    case (sel)
      2'h0:    mode_cfg = `JTX_MODE0;
      2'h1:    mode_cfg = `JTX_MODE1;
      2'h2:    mode_cfg = `JTX_MODE2;
      default: mode_cfg = `JTX_MODE3;
    endcase
  endfunction

  // Self-synchronous scrambler, MSB first, returns {state, data}
  function automatic jtx_pkg::jtx_scr_t scram(input logic [63:0] d, input logic [57:0] s, input logic c64);
    logic [57:0] st;
    logic [63:0] o;
    logic        fb;
    st = s;
    o  = '0;
    for (int i = 63; i >= 0; i--) begin
      fb   = c64 ? (st[`JTX_T64_A] ^ st[`JTX_T64_B]) : (st[`JTX_T8_A] ^ st[`JTX_T8_B]); // [R15]
      o[i] = d[i] ^ fb;
      st   = {st[56:0], o[i]};
    end
    scram = {st, o};
  endfunction

  jtx_pkg::jtx_mode_s mode;
  logic [11:0]        mf_len;
  logic               scr_on;

  assign mode   = mode_cfg(transport_mode_select_i);                  // [R10]
  assign mf_len = 12'((14'(mode.f) * 14'(mode.k)) >> 3);               // [R25] [R11]
  assign scr_on = mode.c64 | scramble_enable_i;                        // [R12]

  // ****************************************
  // Two-entry input buffer
  // ****************************************
  jtx_pkg::jtx_smp_t buf_q [2];
  logic              wp_q;
  logic              rp_q;
  logic [1:0]        cnt_q;
  logic              push;
  logic              pop;
  jtx_pkg::jtx_state_e st_q;

  assign smp_ready_o = (cnt_q != 2'h2);
  assign push        = smp_valid_i & smp_ready_o;
  assign pop         = (st_q == jtx_pkg::ST_DATA) & (cnt_q != 2'h0);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) wp_q <= ~wp_q;
      if (pop) rp_q <= ~rp_q;
      cnt_q <= cnt_q + 2'(push) - 2'(pop);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (push) buf_q[wp_q] <= smp_data_i;
  end

  // ****************************************
  // SYSREF, SYNC and LMFC counter
  // ****************************************
  logic        sysref_q;
  logic        sync_q;
  logic        sync_seen_q;
  logic [11:0] lmfc_q;
  logic        sysref_rise;
  logic        lmfc_edge;
  logic        mf_end;

  assign sysref_rise = sysref_i & ~sysref_q;
  assign lmfc_edge   = (lmfc_q == 12'h0);
  assign mf_end      = (lmfc_q == mf_len - 12'h1);
  assign lmfc_edge_o = lmfc_edge;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sysref_q <= 1'b0;
      sync_q   <= 1'b1;
      lmfc_q   <= 12'h0;                                               // [R26]
    end else begin
      sysref_q <= sysref_i;
      sync_q   <= sync_request_pin_n_i;
      if (sysref_rise) lmfc_q <= 12'h0;                                // [R7] [R19]
      else if (mf_end) lmfc_q <= 12'h0;                                // [R11] [R20]
      else lmfc_q <= lmfc_q + 12'h1;
    end
  end

  // NCO sync pulse and FEC status in 64B/66B modes
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nco_sync_o   <= 1'b0;
      fec_active_o <= 1'b0;
    end else begin
      nco_sync_o   <= mode.c64 & sync_q & ~sync_request_pin_n_i;      // [R6]
      fec_active_o <= mode.c64 & fec_enable_i;                         // [R17] [R18]
    end
  end

  // ****************************************
  // Link state machine
  // ****************************************
  logic [1:0] ilas_mf_q;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q        <= jtx_pkg::ST_IDLE;
      sync_seen_q <= 1'b0;
      ilas_mf_q   <= 2'h0;
    end else begin
      if (st_q != jtx_pkg::ST_CGS) sync_seen_q <= 1'b0;
      else if (sync_request_pin_n_i & ~sync_q) sync_seen_q <= 1'b1;   // [R21]
      if (st_q != jtx_pkg::ST_ILAS) ilas_mf_q <= 2'h0;
      else if (mf_end) ilas_mf_q <= ilas_mf_q + 2'h1;
      case (st_q)
        jtx_pkg::ST_IDLE: begin
          if (mode.c64) begin
            if (lmfc_edge) st_q <= jtx_pkg::ST_DATA;                   // [R5]
          end else if (!sync_q) begin
            st_q <= jtx_pkg::ST_CGS;                                   // [R4]
          end
        end
        jtx_pkg::ST_CGS: begin
          if (mode.c64) st_q <= jtx_pkg::ST_IDLE;
          // Leave on the last multiframe cycle so the first alignment word sits on the LMFC edge
          else if (sync_seen_q & sync_q & mf_end) st_q <= jtx_pkg::ST_ILAS; // [R23]
        end
        jtx_pkg::ST_ILAS: begin
          if (mode.c64) st_q <= jtx_pkg::ST_IDLE;
          else if (!sync_q) st_q <= jtx_pkg::ST_CGS;
          else if (mf_end && ilas_mf_q == `JTX_ILAS_LAST) st_q <= jtx_pkg::ST_DATA;
        end
        jtx_pkg::ST_DATA: begin
          if (!mode.c64 && !sync_q) st_q <= jtx_pkg::ST_CGS;           // [R4] [R2]
        end
        default: st_q <= jtx_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Sample packing and lane mapping
  // ****************************************
  logic [255:0] word;
  jtx_pkg::jtx_smp_t head;

  assign head = buf_q[rp_q];

  always_comb begin
    word = '0;
    for (int i = 0; i < `JTX_SMP_NUM; i++) begin
      if (pop) word[i*`JTX_SMP_NP +: `JTX_SMP_NP] = {head[i*`JTX_SMP_N +: `JTX_SMP_N], 7'h00}; // [R9] [R8]
    end
  end

  // ****************************************
  // Per-lane scrambling and symbol selection
  // ****************************************
  logic [57:0] scr_q [`JTX_LANES];

  for (genvar l = 0; l < `JTX_LANES; l++) begin : g_lane
    logic              act;
    jtx_pkg::jtx_scr_t sr;
    logic [63:0]       d_d;
    logic [7:0]        k_d;
    logic [7:0]        ramp;

    assign act  = (3'(l) < mode.lanes);                                // [R3]
    assign sr   = scram(word[l*64 +: 64], scr_q[l], mode.c64);         // [R13] [R16]
    assign ramp = lmfc_q[7:0];

    always_comb begin
      d_d = '0;
      k_d = '0;
      case (st_q)
        jtx_pkg::ST_CGS: begin
          d_d = {8{`JTX_K28_5}};                                       // [R22]
          k_d = 8'hff;
        end
        jtx_pkg::ST_ILAS: begin
          d_d = {8{ramp}};                                             // [R14]
          if (lmfc_edge) begin
            d_d[63:56] = `JTX_K28_0;
            k_d[7]     = 1'b1;
          end
          if (mf_end) begin
            d_d[7:0] = `JTX_K28_3;
            k_d[0]   = 1'b1;
          end
        end
        jtx_pkg::ST_DATA: d_d = scr_on ? sr[63:0] : word[l*64 +: 64]; // [R12] [R24]
        default: d_d = '0;
      endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        scr_q[l]        <= '0;                                         // [R26]
        lane_data_o[l]  <= '0;
        lane_k_o[l]     <= '0;
        lane_hdr_o[l]   <= '0;
        lane_valid_o[l] <= 1'b0;
      end else begin
        if (st_q == jtx_pkg::ST_DATA && scr_on) scr_q[l] <= sr[121:64];
        lane_data_o[l]  <= act ? d_d : '0;
        lane_k_o[l]     <= act ? k_d : '0;
        lane_hdr_o[l]   <= (act && mode.c64 && st_q == jtx_pkg::ST_DATA) ? `JTX_SH_DATA : 2'h0; // [R24] [R1]
        lane_valid_o[l] <= act && st_q != jtx_pkg::ST_IDLE;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_sysref_lmfc_zero: assert property (sysref_rise |=> lmfc_q == 12'h0) // [R7]
    else $error("LMFC counter not reset by SYSREF");
  a_cgs_commas_out: assert property (st_q == jtx_pkg::ST_CGS |=> lane_data_o[0] == {8{`JTX_K28_5}} && lane_k_o[0] == 8'hff) // [R22]
    else $error("Commas not sent during CGS");
  a_cgs_on_sync: assert property (st_q == jtx_pkg::ST_DATA && !mode.c64 && !sync_q |=> st_q == jtx_pkg::ST_CGS) // [R4]
    else $error("SYNC low did not start CGS");
  a_ilas_on_edge: assert property ($rose(st_q == jtx_pkg::ST_ILAS) |-> lmfc_edge) // [R23]
    else $error("ILAS began off an LMFC edge");
  a_ilas_r_char: assert property (st_q == jtx_pkg::ST_ILAS && lmfc_edge |=> lane_data_o[0][63:56] == `JTX_K28_0 && lane_k_o[0][7]) // [R14]
    else $error("ILAS multiframe lacks start marker");
  a_sync_ignore_64: assert property (st_q == jtx_pkg::ST_DATA && mode.c64 && $stable(mode) |=> st_q == jtx_pkg::ST_DATA) // [R5]
    else $error("SYNC disturbed a 64B/66B link");
  a_hdr_in_64: assert property (st_q == jtx_pkg::ST_DATA && mode.c64 && $stable(mode) |=> lane_hdr_o[0] == `JTX_SH_DATA) // [R24]
    else $error("Sync header missing");
  a_lane_limit: assert property (mode.lanes == 3'h1 && $stable(mode) |=> lane_valid_o[3:1] == 3'h0) // [R3]
    else $error("Unused lane active");
  // Self-synchronous scrambler: its state must be the last 58 bits sent on the lane
  a_scr_forced: assert property (st_q == jtx_pkg::ST_DATA && mode.c64 |=> scr_q[0] == lane_data_o[0][57:0]) // [R12]
    else $error("Scrambling off in 64B/66B mode");
  a_lmfc_wrap: assert property (mf_end && !sysref_rise |=> lmfc_edge) // [R25]
    else $error("LMFC period wrong");

  c_full_init: cover property (st_q == jtx_pkg::ST_ILAS ##1 st_q == jtx_pkg::ST_DATA);
  c_buffer_full: cover property (cnt_q == 2'h2);
  c_resync: cover property (st_q == jtx_pkg::ST_DATA ##1 st_q == jtx_pkg::ST_CGS);
  c_data_64: cover property (st_q == jtx_pkg::ST_DATA && mode.c64 && pop);

endmodule // jtx_link

/* dv/jtx_rx_model.sv */
// Receiver-side model: requests the link and releases the request after commas
`timescale 1ns/1ps
`include "jtx_params.svh"
module jtx_rx_model (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  // Bench control
  input  wire logic             start_i,
  input  wire logic             slow_i,
  // Link to and from the transmitter
  input  wire logic [3:0][63:0] lane_data_i,
  input  wire logic [3:0][7:0]  lane_k_i,
  input  wire logic             lmfc_edge_i,
  output logic                  sync_n_o
);
  logic sync_n_q;
  logic cgs_q;
  logic skip_q;
  assign sync_n_o = sync_n_q;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_n_q <= 1'b1;
      cgs_q    <= 1'b0;
      skip_q   <= 1'b0;
    end else if (start_i) begin
      sync_n_q <= 1'b0;
      cgs_q    <= 1'b0;
      skip_q   <= slow_i;
    end else if (!sync_n_q && !cgs_q) begin
      // Eight commas in one word exceed the four needed for lock
      cgs_q <= lane_k_i[0] === 8'hff && lane_data_i[0] === {8{`JTX_K28_5}};
    end else if (!sync_n_q && lmfc_edge_i) begin
      // A slow receiver lets one multiframe edge pass first
      skip_q   <= 1'b0;
      sync_n_q <= ~skip_q;
    end
  end
endmodule // jtx_rx_model

/* dv/jtx_link_tb.sv */
// Self-checking bench of the converter transmit link
`timescale 1ns/1ps
`include "jtx_params.svh"
module jtx_link_tb;
  logic              ref_clk;
  logic              rst_n;
  logic [1:0]        mode;
  logic              scramble_enable;
  logic              fec;
  logic              sysref;
  logic              sval;
  jtx_pkg::jtx_smp_t sdata;
  logic              start;
  logic              slow;
  logic              sync_n;
  logic              ready;
  logic [3:0][63:0]  ldata;
  logic [3:0][7:0]   lk;
  logic [3:0][1:0]   lhdr;
  logic [3:0]        lval;
  logic              fec_act;
  logic              nco;
  logic              lmfc;
  int                miscompares;
  int                n_compared;
  int                k;
  jtx_link dut (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .transport_mode_select_i(mode),
    .scramble_enable_i(scramble_enable), .fec_enable_i(fec), .sync_request_pin_n_i(sync_n), .sysref_i(sysref),
    .smp_valid_i(sval), .smp_data_i(sdata), .smp_ready_o(ready), .lane_data_o(ldata),
    .lane_k_o(lk), .lane_hdr_o(lhdr), .lane_valid_o(lval), .fec_active_o(fec_act),
    .nco_sync_o(nco), .lmfc_edge_o(lmfc));
  jtx_rx_model rx (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .start_i(start), .slow_i(slow),
    .lane_data_i(ldata), .lane_k_i(lk), .lmfc_edge_i(lmfc), .sync_n_o(sync_n));
  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("compared=%0d miscompares=%0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic ng();
    @(negedge ref_clk);
  endtask
  // Lane image of a word: 16-bit fields, lanes beyond nl left zero
  function automatic logic [255:0] raw(input logic [7:0] b, input int nl);
    raw = '0;
    for (int i = 0; i < 4 * nl; i++) raw[i*16+:16] = {{1'b0, b} + 9'(i), 7'h0};
  endfunction
  function automatic jtx_pkg::jtx_smp_t smp(input logic [7:0] b);
    for (int i = 0; i < 16; i++) smp[i*9+:9] = {1'b0, b} + 9'(i);
  endfunction
  task automatic reset(input logic [1:0] m, input logic s);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    sval  <= 1'b0;
    mode  <= m;
    scramble_enable   <= s;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
  endtask
  task automatic push(input logic [7:0] b);
    sval  <= 1'b1;
    sdata <= smp(b);
    k = 0;
    do @(posedge ref_clk); while (ready !== 1'b1 && ++k < 50);
  endtask
  // Receiver descrambler: its state is the last 58 received bits
  function automatic logic [63:0] descr(input logic [63:0] p, input logic [63:0] c, input logic c64);
    logic [57:0] st;
    st = p[57:0];
    for (int i = 63; i >= 0; i--) begin
      descr[i] = c[i] ^ (c64 ? (st[`JTX_T64_A] ^ st[`JTX_T64_B]) : (st[`JTX_T8_A] ^ st[`JTX_T8_B]));
      st       = {st[56:0], c[i]};
    end
  endfunction
  // Raw word must never reach lane 0 while scrambling is on, yet a descrambler must recover it
  task automatic noraw(input logic [7:0] b, input logic c64);
    int           hits;
    int           found;
    logic [255:0] r;
    logic [63:0]  prev;
    hits  = 0;
    found = 0;
    r     = raw(b, 1);
    ng();
    prev = ldata[0];
    repeat (8) begin
      ng();
      if (ldata[0] === r[63:0]) hits++;
      if (descr(prev, ldata[0], c64) === r[63:0]) found++;
      prev = ldata[0];
    end
    check(hits, 0);
    check(found != 0, 1'b1);
  endtask
  // Link-up in 8B/10B: commas, buffer filled while stalled, alignment multiframes
  task automatic link(input logic [1:0] m, input logic s, input int ml);
    reset(m, s);
    slow  <= m[0];
    start <= 1'b1;
    @(posedge ref_clk);
    start <= 1'b0;
    k = 0;
    do ng(); while (lk[0] !== 8'hff && ++k < 20);
    check(ldata[0], {8{`JTX_K28_5}});
    check(lval, m[0] ? 4'h3 : 4'hf);
    @(posedge ref_clk);
    push(8'h10);
    push(8'h20);
    sdata <= smp(8'h30);
    ng();
    check(ready, 1'b0);
    k = 0;
    do ng(); while (!(lk[0][7] === 1'b1 && ldata[0][63:56] === `JTX_K28_0) && ++k < 400);
    for (int j = 0; j < 4; j++) begin
      check({lk[0][7], ldata[0][63:56]}, {1'b1, `JTX_K28_0});
      repeat (ml - 1) ng();
      check({lk[0][0], ldata[0][7:0]}, {1'b1, `JTX_K28_3});
      ng();
    end
    check(lk[0][7], 1'b0);
  endtask
  task automatic t_raw();
    link(2'h1, 1'b0, 16);
    k = 0;
    while (ldata !== raw(8'h10, 2) && ++k < 8) ng();
    for (int j = 1; j < 4; j++) begin
      check(ldata, raw(8'(j * 16), 2));
      ng();
    end
    // Receiver asks for a new link while data flows
    @(posedge ref_clk);
    start <= 1'b1;
    @(posedge ref_clk);
    start <= 1'b0;
    k = 0;
    do ng(); while (lk[0] !== 8'hff && ++k < 8);
    check(ldata[0], {8{`JTX_K28_5}});
  endtask
  task automatic t64();
    reset(2'h2, 1'b0);
    fec <= 1'b1;
    k = 0;
    do ng(); while (lval !== 4'hf && ++k < 60);
    check(lhdr, 8'h55);
    check(fec_act, 1'b1);
    @(posedge ref_clk);
    start <= 1'b1;
    @(posedge ref_clk);
    start <= 1'b0;
    k = 0;
    do ng(); while (nco !== 1'b1 && ++k < 6);
    check(nco, 1'b1);
    ng();
    check({nco, lk, lval}, 37'hf);
    @(posedge ref_clk);
    push(8'h40);
    noraw(8'h40, 1'b1);
    reset(2'h3, 1'b0);
    k = 0;
    do ng(); while (lval === 4'h0 && ++k < 80);
    check(lval, 4'h1);
  endtask
  task automatic t_sysref();
    reset(2'h0, 1'b0);
    repeat (10) @(posedge ref_clk);
    sysref <= 1'b1;
    @(posedge ref_clk);
    sysref <= 1'b0;
    ng();
    check(lmfc, 1'b1);
    k = 0;
    do ng(); while (lmfc !== 1'b1 && ++k < 40);
    check(k, 31);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    conclude();
  end
  initial begin
    {rst_n, mode, scramble_enable, fec, sysref, sval, start, slow} = '0;
    sdata = '0;
    miscompares = 0;
    n_compared = 0;
    repeat (3) ng();
    check({lval, lk, lhdr, fec_act, nco, ready, lmfc}, 48'h3);
    check(ldata, 256'h0);
    repeat (18) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_sysref();
    link(2'h0, 1'b1, 32);
    noraw(8'h30, 1'b0);
    t_raw();
    t64();
    conclude();
  end
endmodule // jtx_link_tb
